// [logic/dtec_top.v]
`timescale 1ns/1ns
`include "dtec_map.vh"

// Operation
// RULE1: Timer 0 control bit 4 starts counting when 1, stops when 0.
// RULE2: Mode bits 7:6 select event 01, timer 10, pulse width 11; 00 unused.
// RULE3: Bit 5 of both controls and timer 1 bits 2:0 read zero.
// RULE4: Edge bit picks count edge, or start/stop edge pair in pulse mode.
// RULE5: Timer 1 control bit 4 starts counting when 1, stops when 0.
// RULE6: Pulse mode starts and stops on input transitions, not levels.
// RULE7: Pulse mode overflow reloads from preload and raises the request.
// RULE8: Pulse mode clears the run bit at completion; others only by software.
// RULE9: Either timer overflow is a wake-up source ending halt.
// RULE10: Clearing an interrupt enable hides that request but keeps counting.
// RULE11: Writing a stopped timer loads both preload and counter.
// RULE12: Writing a running timer loads preload only; used at next reload.
// RULE13: Reading a count blocks that timer's count clock for that cycle.
// RULE14: Timer 0 control bits 2:0 select the prescaler division.
// RULE15: Timer 0 overflows toggle a square wave for the buzzer.
// RULE16: With buzzer option, output pins 0/1 of port B drive wave and complement.
// RULE17: With buzzer option, a pin set as input stays an input.
// RULE18: With buzzer option, only the port B bit 0 latch gates both pins.
// RULE19: Buzzer output pin drives 0 when bit 0 latch is 0, else its phase.
// RULE20: Timer 0 input shares port C bit 0; timer 1 uses port C bit 5.
// RULE21: Prescale codes 000 to 111 divide the clock by 2 up to 256.
// RULE22: Counter counts up to FFH, reloads, and sets flag bit 5 or 6.
// RULE23: A finished measurement holds and ignores edges until run is set again.
// RULE24: Timer 1 internal clock is the system clock divided by 4.
// RULE25: Input pins pass two flops before edge detection, one event per edge.
module dtec_top (
    input wire core_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire portc_bit0,
    input wire portc_bit5,
    input wire buzzer_option,
    output reg portb_bit0_out,
    output reg portb_bit0_oe_n,
    output reg portb_bit1_out,
    output reg portb_bit1_oe_n,
    output reg timer0_irq,
    output reg timer1_irq,
    output reg timer_wakeup
);

    // Synchroniser stages for the two count pins.
    reg [1:0] pin_meta;
    reg [1:0] pin_sync;

    // Edge detector history.
    reg [1:0] pin_last;

    // Option pin stages.
    reg buz_meta;
    reg buz_sync;

    // Shared free-running prescaler and the derived timer ticks.
    reg [7:0] prescale;

    // Divider decode and ticks.
    wire [2:0] psc_sel;
    wire [3:0] psc_shift;
    wire [7:0] psc_mask;
    wire tick0;
    wire tick1;

    // Software-visible state outside the timers.
    reg [7:0] int_ctrl;
    reg [7:0] next_int_ctrl;

    // Port B and buzzer state.
    reg [7:0] pb_data;
    reg [7:0] pb_dir;
    reg prog_freq_square_wave;

    // Read mux output.
    reg [7:0] next_rdata;

    // Per-timer results gathered from the generate loop.
    wire [1:0] ovf;
    wire [15:0] ctrl_bus;
    wire [15:0] count_bus;

    // Raw pin pair.
    wire [1:0] pin_raw;

    // Timer 0 counts on port C bit 0 and timer 1 on port C bit 5.
    assign pin_raw = {portc_bit5, portc_bit0}; // RULE20

    // Only the second stage feeds logic, so a metastable first stage
    // never reaches the edge detectors.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_last <= 2'h0;
            buz_meta <= 1'b0;
            buz_sync <= 1'b0;
        end else begin
            pin_meta <= pin_raw; // RULE25
            pin_sync <= pin_meta; // RULE25
            pin_last <= pin_sync;

            // The option crosses domains too.
            buz_meta <= buzzer_option;
            buz_sync <= buz_meta;
        end
    end

    // The prescaler runs always, so a timer started mid-count may see a
    // short first period; that is the price of sharing one divider.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prescale <= 8'h00;
        end else begin
            prescale <= prescale + 8'h01;
        end
    end

    // A tick fires when the selected low prescaler bits are all ones.
    assign psc_sel = ctrl_bus[`DTEC_PSC_MSB:`DTEC_PSC_LSB]; // RULE14
    assign psc_shift = {1'b0, psc_sel} + 4'h1;
    assign psc_mask = ~(8'hff << psc_shift); // RULE21
    assign tick0 = &(prescale | ~psc_mask); // RULE21

    // Fixed divide by 4.
    assign tick1 = &prescale[`DTEC_T1_DIV_LOG2-1:0]; // RULE24

    // One copy per timer.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_tmr
            localparam [7:0] CTRL_ADDR = (i == 0) ? `DTEC_ADDR_T0_CTRL : `DTEC_ADDR_T1_CTRL;
            localparam [7:0] CNT_ADDR = (i == 0) ? `DTEC_ADDR_T0_COUNT : `DTEC_ADDR_T1_COUNT;
            localparam [7:0] CTRL_MASK = (i == 0) ? `DTEC_T0_CTRL_MASK : `DTEC_T1_CTRL_MASK;

            // Timer state.
            reg [7:0] ctrl;
            reg [7:0] preload;
            reg [7:0] count;
            reg pulse_active;
            reg inc;

            // Control fields.
            wire [1:0] mode;
            wire run;
            wire edge_sel;

            // Edge decodes.
            wire rise;
            wire fall;
            wire count_edge;
            wire start_edge;
            wire stop_edge;

            // Tick and bus decodes.
            wire tick;
            wire read_block;
            wire wr_count;
            wire wr_ctrl;

            // Measurement status.
            wire pulse_mode;
            wire pulse_done;

            // Control fields and bus decodes for this timer.
            assign mode = ctrl[`DTEC_MODE_MSB:`DTEC_MODE_LSB];
            assign run = ctrl[`DTEC_RUN_BIT];
            assign edge_sel = ctrl[`DTEC_EDGE_BIT];
            assign tick = (i == 0) ? tick0 : tick1;
            assign wr_count = reg_write & (reg_addr == CNT_ADDR);
            assign wr_ctrl = reg_write & (reg_addr == CTRL_ADDR);
            assign read_block = reg_read & (reg_addr == CNT_ADDR); // RULE13
            assign pulse_mode = (mode == `DTEC_MODE_PULSE);

            // Edges come from the synchronised level, one event per edge.
            assign rise = pin_sync[i] & ~pin_last[i]; // RULE25
            assign fall = ~pin_sync[i] & pin_last[i]; // RULE25
            assign count_edge = edge_sel ? fall : rise; // RULE4
            assign start_edge = edge_sel ? rise : fall; // RULE4
            assign stop_edge = edge_sel ? fall : rise; // RULE4

            // A measurement ends on the opposite edge of the one that began it.
            assign pulse_done = run & pulse_mode & pulse_active & stop_edge; // RULE6

            // Count clock per mode; a read of the count swallows that cycle.
            always @* begin
                case (mode)
                    `DTEC_MODE_EVENT: inc = run & count_edge; // RULE2
                    `DTEC_MODE_TIMER: inc = run & tick; // RULE2
                    `DTEC_MODE_PULSE: inc = run & pulse_active & tick; // RULE2
                    default: inc = 1'b0;
                endcase

                if (read_block) begin
                    inc = 1'b0; // RULE13
                end
            end

            // Overflow is a count at the top value.
            assign ovf[i] = inc & (count == `DTEC_COUNT_MAX); // RULE22

            // Counter and preload; a running timer keeps its count on a write.
            always @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    preload <= 8'h00;
                    count <= 8'h00;
                end else begin
                    if (wr_count) begin
                        preload <= reg_wdata; // RULE12
                    end

                    if (wr_count && !run) begin
                        count <= reg_wdata; // RULE11
                    end else if (ovf[i]) begin
                        count <= preload; // RULE7
                    end else if (inc) begin
                        count <= count + 8'h01; // RULE22
                    end
                end
            end

            // Software writes win over the automatic run clear in one cycle,
            // so a rearm issued as a measurement ends is not lost.
            always @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    ctrl <= `DTEC_CTRL_RST;
                end else if (wr_ctrl) begin
                    ctrl <= reg_wdata & CTRL_MASK; // RULE1 RULE5 RULE3
                end else if (pulse_done) begin
                    ctrl[`DTEC_RUN_BIT] <= 1'b0; // RULE8 RULE23
                end
            end

            // Measurement state: armed by run, started by a transition only,
            // so a level already present when run is set is not measured.
            always @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    pulse_active <= 1'b0;
                end else if (!run || !pulse_mode) begin
                    pulse_active <= 1'b0;
                end else if (!pulse_active && start_edge) begin
                    pulse_active <= 1'b1; // RULE6
                end else if (pulse_active && stop_edge) begin
                    pulse_active <= 1'b0; // RULE6
                end
            end

            // Results for the read mux.
            assign ctrl_bus[i*8 +: 8] = ctrl;
            assign count_bus[i*8 +: 8] = count;
        end
    endgenerate

    // Overflow flags are set by hardware; a set beats a software clear.
    always @* begin
        next_int_ctrl = int_ctrl;
        if (reg_write && reg_addr == `DTEC_ADDR_INT_CTRL) begin
            next_int_ctrl = reg_wdata & `DTEC_INT_MASK;
        end

        // Sets come last, so they win.
        if (ovf[0]) begin
            next_int_ctrl[`DTEC_T0_FLAG_BIT] = 1'b1; // RULE22 RULE7
        end
        if (ovf[1]) begin
            next_int_ctrl[`DTEC_T1_FLAG_BIT] = 1'b1; // RULE22 RULE7
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            int_ctrl <= `DTEC_INT_RST;
        end else begin
            int_ctrl <= next_int_ctrl;
        end
    end

    // Requests are gated by the enables only; the counters never stop here.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timer0_irq <= 1'b0;
            timer1_irq <= 1'b0;
            timer_wakeup <= 1'b0;
        end else begin
            timer0_irq <= int_ctrl[`DTEC_T0_FLAG_BIT] & int_ctrl[`DTEC_T0_IE_BIT]; // RULE10
            timer1_irq <= int_ctrl[`DTEC_T1_FLAG_BIT] & int_ctrl[`DTEC_T1_IE_BIT]; // RULE10

            // One pulse per cycle in which either timer overflows.
            timer_wakeup <= |ovf; // RULE9
        end
    end

    // The square wave toggles on every timer 0 overflow.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prog_freq_square_wave <= 1'b0;
        end else if (ovf[0]) begin
            prog_freq_square_wave <= ~prog_freq_square_wave; // RULE15
        end
    end

    // Port B bit 0/1 latches and directions, needed for buzzer gating.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pb_data <= `DTEC_PB_RST;
            pb_dir <= `DTEC_PB_RST;
        end else if (reg_write) begin
            if (reg_addr == `DTEC_ADDR_PB_DATA) begin
                pb_data <= reg_wdata;
            end

            if (reg_addr == `DTEC_ADDR_PB_DIR) begin
                pb_dir <= reg_wdata;
            end
        end
    end

    // Pad drive: a direction bit of 1 leaves the pin an input in every
    // option; with the buzzer option both pins follow the bit 0 latch.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            portb_bit0_out <= 1'b0;
            portb_bit1_out <= 1'b0;
            portb_bit0_oe_n <= 1'b1;
            portb_bit1_oe_n <= 1'b1;
        end else begin
            portb_bit0_oe_n <= pb_dir[0]; // RULE17
            portb_bit1_oe_n <= pb_dir[1]; // RULE17

            // Bit 1 latch unused here.
            if (buz_sync) begin
                portb_bit0_out <= pb_data[0] & prog_freq_square_wave; // RULE16 RULE19
                portb_bit1_out <= pb_data[0] & ~prog_freq_square_wave; // RULE18 RULE19
            end else begin
                portb_bit0_out <= pb_data[0];
                portb_bit1_out <= pb_data[1];
            end
        end
    end

    // Read multiplexer; unmapped addresses answer zero.
    always @* begin
        case (reg_addr)
            `DTEC_ADDR_INT_CTRL: next_rdata = int_ctrl;
            `DTEC_ADDR_T0_COUNT: next_rdata = count_bus[7:0];
            `DTEC_ADDR_T0_CTRL: next_rdata = ctrl_bus[7:0] & `DTEC_T0_CTRL_MASK; // RULE3
            `DTEC_ADDR_T1_COUNT: next_rdata = count_bus[15:8];
            `DTEC_ADDR_T1_CTRL: next_rdata = ctrl_bus[15:8] & `DTEC_T1_CTRL_MASK; // RULE3
            `DTEC_ADDR_PB_DATA: next_rdata = pb_data;
            `DTEC_ADDR_PB_DIR: next_rdata = pb_dir;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data appear in the cycle after the strobe and only there.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // dtec_top

// [shared/dtec_map.vh]
`ifndef DTEC_MAP_VH
`define DTEC_MAP_VH

// Register locations on the internal register port.
`define DTEC_ADDR_INT_CTRL 8'h0b
`define DTEC_ADDR_T0_COUNT 8'h0d
`define DTEC_ADDR_T0_CTRL 8'h0e
`define DTEC_ADDR_T1_COUNT 8'h10
`define DTEC_ADDR_T1_CTRL 8'h11
`define DTEC_ADDR_PB_DATA 8'h14
`define DTEC_ADDR_PB_DIR 8'h15

// Timer control register fields.
`define DTEC_PSC_LSB 0
`define DTEC_PSC_MSB 2
`define DTEC_EDGE_BIT 3
`define DTEC_RUN_BIT 4
`define DTEC_MODE_LSB 6
`define DTEC_MODE_MSB 7

// Operating mode codes.
`define DTEC_MODE_EVENT 2'h1
`define DTEC_MODE_TIMER 2'h2
`define DTEC_MODE_PULSE 2'h3

// Interrupt control register fields.
`define DTEC_T0_IE_BIT 2
`define DTEC_T1_IE_BIT 3
`define DTEC_T0_FLAG_BIT 5
`define DTEC_T1_FLAG_BIT 6

// Reset values and implemented-bit masks.
`define DTEC_CTRL_RST 8'h08
`define DTEC_INT_RST 8'h00
`define DTEC_PB_RST 8'hff
`define DTEC_T0_CTRL_MASK 8'hdf
`define DTEC_T1_CTRL_MASK 8'hd8
`define DTEC_INT_MASK 8'h6c

// Counter limits and the fixed timer 1 divider.
`define DTEC_COUNT_MAX 8'hff
`define DTEC_T1_DIV_LOG2 2

`endif

// [tb/dtec_chk.sv]
`timescale 1ns/1ns
`include "dtec_map.vh"

// Port-level checks on the register port, the buzzer pins and the request outputs.
module dtec_chk (
    input wire core_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire buzzer_option,
    input wire portb_bit0_out,
    input wire portb_bit0_oe_n,
    input wire portb_bit1_out,
    input wire portb_bit1_oe_n,
    input wire timer0_irq,
    input wire timer1_irq,
    input wire timer_wakeup
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Unimplemented control bits read back as zero.
    property p_t0_unused;
        reg_read && reg_addr == `DTEC_ADDR_T0_CTRL |=> reg_rdata[5] == 1'b0;
    endproperty
    a_t0_unused: assert property (p_t0_unused) else $error("timer 0 control unused bit read as one");
    property p_t1_unused;
        reg_read && reg_addr == `DTEC_ADDR_T1_CTRL |=> (reg_rdata & 8'h27) == 8'h00;
    endproperty
    a_t1_unused: assert property (p_t1_unused) else $error("timer 1 control unused bit read as one");

    // A request that rises without a software write behind it must come from an overflow, so it wakes.
    property p_wake0;
        $rose(timer0_irq) && !$past(reg_write, 2) |-> $past(timer_wakeup);
    endproperty
    a_wake0: assert property (p_wake0) else $error("timer 0 overflow without wake pulse");
    property p_wake1;
        $rose(timer1_irq) && !$past(reg_write, 2) |-> $past(timer_wakeup);
    endproperty
    a_wake1: assert property (p_wake1) else $error("timer 1 overflow without wake pulse");

    // A cleared enable hides the request two cycles on, whatever the flag does.
    property p_mask0;
        reg_write && reg_addr == `DTEC_ADDR_INT_CTRL && !reg_wdata[2] |-> ##2 !timer0_irq;
    endproperty
    a_mask0: assert property (p_mask0) else $error("timer 0 request seen while disabled");
    property p_mask1;
        reg_write && reg_addr == `DTEC_ADDR_INT_CTRL && !reg_wdata[3] |-> ##2 !timer1_irq;
    endproperty
    a_mask1: assert property (p_mask1) else $error("timer 1 request seen while disabled");

    // In buzzer mode the pair carries a wave and its complement, gated by one latch, never both high.
    property p_buz_pair;
        buzzer_option [*4] |-> !(portb_bit0_out && portb_bit1_out);
    endproperty
    a_buz_pair: assert property (p_buz_pair) else $error("both buzzer pins high");

    // The direction bits alone decide whether the pins drive.
    property p_dir_oe;
        reg_write && reg_addr == `DTEC_ADDR_PB_DIR ##1 !(reg_write && reg_addr == `DTEC_ADDR_PB_DIR)
            |=> portb_bit0_oe_n == $past(reg_wdata[0], 2) && portb_bit1_oe_n == $past(reg_wdata[1], 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("pin enable differs from direction");
endmodule // dtec_chk

// [tb/dtec_src.sv]
`timescale 1ns/1ns

// Pulse source for one timer input pin: n pulses of w cycles away from the idle level, each followed by w idle cycles.
// Widths of at least 2 keep each level long enough for the pin synchroniser.
module dtec_src (
    input wire core_clk,
    input wire go,
    input wire idle_level,
    input wire [7:0] n_pulse,
    input wire [7:0] width,
    output reg pin
);
    reg [7:0] left;
    reg [8:0] ph;

    initial begin
        pin = 1'b0;
        left = 8'h00;
        ph = 9'h000;
    end

    // The pin rests at the idle level between bursts, so an idle change is itself an edge.
    always @(posedge core_clk) begin
        if (left == 8'h00) begin
            pin <= idle_level;
            ph <= 9'h000;
            if (go) begin
                left <= n_pulse;
            end
        end else begin
            pin <= (ph < {1'b0, width}) ? ~idle_level : idle_level;
            ph <= (ph == {width, 1'b0} - 9'h001) ? 9'h000 : ph + 9'h001;
            if (ph == {width, 1'b0} - 9'h001) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule // dtec_src

// [tb/dtec_top_tb.sv]
`timescale 1ns/1ns
`include "dtec_map.vh"

// Drives the register port and two pulse sources, and judges each timer feature in turn.
module dtec_top_tb;
    reg core_clk, reset, reg_write, reg_read, buzzer_option;
    reg [7:0] reg_addr, reg_wdata, npul, wid, v;
    reg [1:0] go, idle;
    wire [7:0] reg_rdata;
    wire pc0, pc5, pb0, pb0_oe_n, pb1, pb1_oe_n, irq0, irq1, wake;
    integer n_errors, tests_run, i, t, e, b;

    dtec_top i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .portc_bit0(pc0), .portc_bit5(pc5),
        .buzzer_option(buzzer_option), .portb_bit0_out(pb0), .portb_bit0_oe_n(pb0_oe_n), .portb_bit1_out(pb1),
        .portb_bit1_oe_n(pb1_oe_n), .timer0_irq(irq0), .timer1_irq(irq1), .timer_wakeup(wake));
    dtec_src i_src0 (.core_clk(core_clk), .go(go[0]), .idle_level(idle[0]), .n_pulse(npul), .width(wid), .pin(pc0));
    dtec_src i_src1 (.core_clk(core_clk), .go(go[1]), .idle_level(idle[1]), .n_pulse(npul), .width(wid), .pin(pc5));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Count register of each timer; its control sits one address above.
    function [7:0] ca(input integer k);
        ca = k ? 8'h10 : 8'h0d;
    endfunction

    // One-cycle strobes; the slave never stalls.
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_write <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_write <= 1'b0;
        end
    endtask
    task chk(input [8*16-1:0] nm, input [7:0] exp, input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
    task rc(input [7:0] a, input [7:0] exp, input [8*16-1:0] nm);
        begin
            @(posedge core_clk);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_read <= 1'b0;
            @(negedge core_clk);
            v = reg_rdata;
            chk(nm, exp, v);
        end
    endtask
    task pulse(input integer s, input [7:0] n, input [7:0] w);
        begin
            @(posedge core_clk);
            npul <= n;
            wid <= w;
            go[s] <= 1'b1;
            @(posedge core_clk);
            go[s] <= 1'b0;
            repeat (2 * n * w + 8) @(posedge core_clk);
        end
    endtask

    task t_regs;
        begin
            rc(`DTEC_ADDR_T0_CTRL, 8'h08, "ctrl0 reset");
            rc(`DTEC_ADDR_T1_CTRL, 8'h08, "ctrl1 reset");
            rc(8'h00, 8'h00, "unmapped");
            wr(`DTEC_ADDR_T0_CTRL, 8'hff);
            rc(`DTEC_ADDR_T0_CTRL, 8'hdf, "ctrl0 bits");
            wr(`DTEC_ADDR_T1_CTRL, 8'hff);
            rc(`DTEC_ADDR_T1_CTRL, 8'hd8, "ctrl1 bits");
            wr(`DTEC_ADDR_T0_CTRL, 8'h00);
            wr(`DTEC_ADDR_T1_CTRL, 8'h00);
            $display("test regs done");
        end
    endtask

    // Each edge choice on each pin; idle level changes only while the timer is stopped.
    task t_event;
        for (t = 0; t < 2; t = t + 1) begin
            for (e = 0; e < 2; e = e + 1) begin
                idle[t] <= e[0];
                wr(ca(t), 8'hf0);
                rc(ca(t), 8'hf0, "count stopped");
                wr(ca(t) + 8'h01, {4'h5, e[0], 3'h0});
                pulse(t, 5, 2);
                rc(ca(t), 8'hf5, "event count");
                rc(ca(t) + 8'h01, {4'h5, e[0], 3'h0}, "run kept");
                wr(ca(t) + 8'h01, {4'h4, e[0], 3'h0});
                pulse(t, 3, 2);
                rc(ca(t), 8'hf5, "count halted");
            end
            $display("test event timer %0d done", t);
        end
    endtask

    task t_ovf;
        for (t = 0; t < 2; t = t + 1) begin
            idle[t] <= 1'b0;
            wr(`DTEC_ADDR_INT_CTRL, t ? 8'h08 : 8'h04);
            wr(ca(t), 8'hfe);
            wr(ca(t) + 8'h01, 8'h50);
            wr(ca(t), 8'h80);
            rc(ca(t), 8'hfe, "count running");
            pulse(t, 2, 2);
            rc(ca(t), 8'h80, "count reload");
            rc(`DTEC_ADDR_INT_CTRL, t ? 8'h48 : 8'h24, "flag set");
            chk("irq on", 8'h01, {7'h00, t ? irq1 : irq0});
            wr(`DTEC_ADDR_INT_CTRL, 8'h00);
            wr(ca(t) + 8'h01, 8'h40);
            wr(ca(t), 8'hff);
            wr(ca(t) + 8'h01, 8'h50);
            pulse(t, 1, 2);
            rc(ca(t), 8'hff, "masked reload");
            rc(`DTEC_ADDR_INT_CTRL, t ? 8'h40 : 8'h20, "flag masked");
            chk("irq off", 8'h00, {7'h00, t ? irq1 : irq0});
            $display("test overflow timer %0d done", t);
        end
    endtask

    // Exactly 256 counting edges between start and stop, so the count is 256 over the divider.
    task t_presc;
        begin
            for (i = 0; i < 9; i = i + 1) begin
                t = i / 8;
                wr(ca(t) + 8'h01, 8'h00);
                wr(ca(t), 8'h00);
                wr(ca(t) + 8'h01, {5'h12, i[2:0]});
                if (i == 0) begin
                    // Reads three cycles apart meet both tick phases, so one count is lost.
                    @(posedge core_clk);
                    reg_read <= 1'b1;
                    reg_addr <= ca(0);
                    @(posedge core_clk);
                    reg_read <= 1'b0;
                    repeat (2) @(posedge core_clk);
                    reg_read <= 1'b1;
                    @(posedge core_clk);
                    reg_read <= 1'b0;
                end
                repeat (i == 0 ? 249 : 254) @(posedge core_clk);
                wr(ca(t) + 8'h01, 8'h80);
                rc(ca(t), t ? 8'h40 : (8'h80 >> i[2:0]) - (i == 0), "divided count");
            end
            $display("test prescale done");
        end
    endtask

    task t_pulse;
        for (t = 0; t < 2; t = t + 1) begin
            idle[t] <= t[0];
            wr(ca(t), 8'h00);
            wr(ca(t) + 8'h01, {4'hd, ~t[0], 3'h0});
            pulse(t, 1, 40);
            rc(ca(t) + 8'h01, {4'hc, ~t[0], 3'h0}, "run cleared");
            e = t ? 10 : 20;
            b = v;
            rc(ca(t), t ? 8'h0a : 8'h14, "width");
            chk("width range", 8'h01, {7'h00, v >= e - 1 && v <= e + 1});
            b = v;
            pulse(t, 1, 40);
            rc(ca(t), b[7:0], "held result");
            $display("test pulse timer %0d done", t);
        end
    endtask

    // Timer 0 overflows every 4 cycles here, so 16 cycles show 4 toggles.
    task t_buzz;
        begin
            @(posedge core_clk);
            buzzer_option <= 1'b1;
            wr(`DTEC_ADDR_PB_DIR, 8'h00);
            wr(`DTEC_ADDR_PB_DATA, 8'h01);
            wr(ca(0), 8'hfe);
            wr(ca(0) + 8'h01, 8'h90);
            repeat (8) @(negedge core_clk);
            e = 0;
            i = 0;
            for (t = 0; t < 16; t = t + 1) begin
                b = pb0;
                @(negedge core_clk);
                e = (pb0 !== b[0]) ? e + 1 : e;
                i = (pb1 !== ~pb0) ? i + 1 : i;
            end
            chk("toggles", 8'h04, e[7:0]);
            chk("complement", 8'h00, i[7:0]);
            chk("drive", 8'h00, {6'h00, pb0_oe_n, pb1_oe_n});
            wr(`DTEC_ADDR_PB_DATA, 8'h02);
            repeat (4) @(negedge core_clk);
            chk("gated", 8'h00, {6'h00, pb0, pb1});
            wr(`DTEC_ADDR_PB_DIR, 8'h03);
            repeat (4) @(negedge core_clk);
            chk("inputs", 8'h03, {6'h00, pb0_oe_n, pb1_oe_n});
            @(posedge core_clk);
            buzzer_option <= 1'b0;
            wr(`DTEC_ADDR_PB_DIR, 8'h00);
            repeat (6) @(negedge core_clk);
            chk("plain latch", 8'h01, {6'h00, pb0, pb1});
            wr(ca(0) + 8'h01, 8'h00);
            $display("test buzzer done");
        end
    endtask

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial begin
        reset = 1'b1;
        {reg_write, reg_read, buzzer_option, go, idle} = 7'h00;
        {reg_addr, reg_wdata, npul, wid} = 32'h0000_0202;
        n_errors = 0;
        tests_run = 0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_regs;
        t_event;
        t_ovf;
        t_presc;
        t_pulse;
        t_buzz;
        print_verdict;
    end

    // The whole run needs well under 10000 cycles; this cuts a hang short.
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        print_verdict;
    end
endmodule // dtec_top_tb

bind dtec_top dtec_chk i_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .buzzer_option(buzzer_option),
    .portb_bit0_out(portb_bit0_out), .portb_bit0_oe_n(portb_bit0_oe_n), .portb_bit1_out(portb_bit1_out),
    .portb_bit1_oe_n(portb_bit1_oe_n), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .timer_wakeup(timer_wakeup));
